// ===== hdl/pfs_consts.vh
/*
 * Constants for the print flow sync and identify block.
 * Assumes inclusion by bare name from design and bench files.
 */
`ifndef PFS_CONSTS_VH
`define PFS_CONSTS_VH

// Character codes
`define PFS_CH_ESC      8'h1b
`define PFS_CH_CR       8'h0d
`define PFS_CH_LF       8'h0a
`define PFS_CH_CAN      8'h18
`define PFS_CH_XON      8'h11
`define PFS_CH_XOFF     8'h13
`define PFS_CH_SLASH    8'h2f
`define PFS_CH_IDENT    8'h5a
`define PFS_CH_PLINE    8'h56
`define PFS_CH_PT_ENTER 8'h57
`define PFS_CH_PT_EXIT  8'h58
// Identify suffixes, arbitrary neutral values
`define PFS_ID_NOPRN    8'h41
`define PFS_ID_PRN      8'h42
// Selector position that picks the parallel printer
`define PFS_SEL_PARALLEL 3'h1
// Screen line length and last column index
`define PFS_COLS        7'h50
`define PFS_COL_LAST    7'h4f
// Wishbone register byte addresses
`define PFS_REG_CTRL    4'h0
`define PFS_REG_STAT    4'h4
`define PFS_REG_SLIPTR  4'h8
// Control register fields
`define PFS_CTRL_LOCAL  0
`define PFS_CTRL_SCRACK 1
// Command decoder states
`define PFS_D_IDLE      2'h0
`define PFS_D_ESC       2'h1
`define PFS_D_PT_ESC    2'h2

`endif

// ===== hdl/pfs_print_flow.v
/*
 * Print flow sync and identify: silo, host flow control, pass-through, identify reply.
 * Assumes a screen engine that consumes proc characters, a printer byte sink with
 * valid/ready, and a host transmitter accepting one byte per valid/ready handshake.
 */
// The placing of the registers and the Wishbone slave port are this design's own decisions.
// Summary of operation
// - Line-follow mode, cursor up onto pending unprinted line stalls processing until printed.
// - Line-follow mode, LF on bottom with top line pending stalls until printed.
// - Otherwise scrolling proceeds in line-follow mode; queued data need not stay put.
// - After print-screen or print-cursor-line, stall until all requested data printed.
// - While stalled, store host characters in the silo and send XOFF.
// - After printing, drain the silo first; send XON only once it is empty.
// - Pass-through uses silo with XOFF/XON to pace host to printer speed.
// - Throughput is slower line rate; no pass-through XOFF when host is slower.
// - Keyboard characters still reach the host during a print stall.
// - Off-line or local copy: stalled keyboard characters also go into silo.
// - Identify request answers with a three-character identification sequence.
// - Printer-present variant only when printer able to print; else no-printer.
// - Serial selector position: deasserted printer DTR reports no printer.
// - Parallel selector: offline or paper fault reports no printer.
// - Selector position 1 is parallel; other positions are serial.
// - Screen line print: columns 1 to 80, then CR, then LF.
// - Each LF in line-follow mode queues the cursor line for printing.
// - Enter command starts raw forwarding; exit sends CAN instead of its last byte.
`timescale 1ns/1ps
`default_nettype none
`include "pfs_consts.vh"

module pfs_print_flow #(
  parameter AW       = 6,   // Silo address width
  parameter DEPTH    = 64,  // Silo depth, power of two
  parameter HEADROOM = 16   // Free slots kept when XOFF goes out
) (
  // Clock and reset
  input  wire        clk_i,
  input  wire        nrst_i,
  // Host receive stream
  input  wire        rx_valid_i,
  input  wire [7:0]  rx_data_i,
  // Keyboard stream
  input  wire        kbd_valid_i,
  input  wire [7:0]  kbd_data_i,
  // Host transmit stream
  output wire        tx_valid_o,
  output reg  [7:0]  tx_data_o,
  input  wire        tx_ready_i,
  // Characters handed to the screen engine
  output reg         proc_valid_o,
  output reg  [7:0]  proc_data_o,
  // Screen engine status and requests
  input  wire        line_follow_i,
  input  wire        cursor_up_pending_i,
  input  wire        cursor_bottom_i,
  input  wire        top_pending_i,
  input  wire        print_req_i,
  input  wire        print_busy_i,
  // Screen line fetch for printing
  input  wire        line_start_i,
  output reg  [6:0]  col_addr_o,
  input  wire [7:0]  col_data_i,
  output reg         line_done_o,
  output reg         lf_queue_o,
  // Printer byte stream
  output reg         prn_valid_o,
  output reg  [7:0]  prn_data_o,
  input  wire        prn_ready_i,
  // Printer status and selector
  input  wire [2:0]  selector_i,
  input  wire        prn_dtr_i,
  input  wire        prn_online_i,
  input  wire        prn_paper_fault_i,
  // Wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [3:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o
);

  // ==========================================================
  // Reset release
  reg rst_a_ff;
  reg rst_b_ff;
  wire rst_n = rst_b_ff;
  // Release through two stages so that the rest leaves reset on a clean edge
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_a_ff <= 1'b0;
      rst_b_ff <= 1'b0;
    end else begin
      rst_a_ff <= 1'b1;
      rst_b_ff <= rst_a_ff;
    end
  end

  // ==========================================================
  // Registers
  reg        local_ff;   // Off-line or local copy operation
  reg        ovf_ff;     // Silo overflow seen, sticky
  // Shared state, declared ahead of every process that reads it
  reg        pt_ff;      // Pass-through active
  reg        xoff_ff;    // XOFF sent, XON still owed
  reg        busy_ff;    // Print stall pending
  reg        line_busy;  // Screen line on its way to the printer
  reg [AW:0] count;      // Silo fill level
  wire       stall;
  wire       prn_able;
  wire       id_sent;
  wire       send_kb;
  wire       wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire       ovf_set;
  // Classic single cycle slave: ack one cycle after request, data registered
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
      local_ff <= 1'b0;
      ovf_ff   <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h0;
      if (wb_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == `PFS_REG_CTRL))
        local_ff <= wb_dat_i[`PFS_CTRL_LOCAL];
      // Set wins over a clear in the same cycle
      if (ovf_set)
        ovf_ff <= 1'b1;
      else if (wb_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == `PFS_REG_STAT) & wb_dat_i[0])
        ovf_ff <= 1'b0;
      if (wb_req & ~wb_we_i) begin
        case (wb_adr_i)
          `PFS_REG_CTRL:   wb_dat_o <= {31'h0, local_ff};
          `PFS_REG_STAT:   wb_dat_o <= {27'h0, prn_able, pt_ff, xoff_ff, stall, ovf_ff};
          `PFS_REG_SLIPTR: wb_dat_o <= {{(31-AW){1'b0}}, count};
          default:         wb_dat_o <= 32'h0;
        endcase
      end
    end
  end

  // ==========================================================
  // Stall conditions and printer capability
  wire stall_lf = line_follow_i & top_pending_i & cursor_bottom_i;
  // Stall is combinational so no pop slips through in the cycle it starts
  assign stall = (line_follow_i & cursor_up_pending_i)
             | busy_ff;
  wire parallel = (selector_i == `PFS_SEL_PARALLEL);
  assign prn_able = parallel ? (prn_online_i & ~prn_paper_fault_i)
                           : prn_dtr_i;

  // ==========================================================
  // Silo
  reg  [7:0]  silo_mem [0:DEPTH-1];
  reg  [AW-1:0] wp_ff;
  reg  [AW-1:0] rp_ff;
  wire [31:0] depth_w = DEPTH;
  // In local copy a stalled key is logged as it leaves for the host, so it is stored once
  wire kbd_in  = send_kb & tx_ready_i & local_ff & stall;
  wire [7:0] wr_data = kbd_in ? kbd_data_i : rx_data_i;
  wire wr_req  = rx_valid_i | kbd_in;
  wire full    = (count == depth_w[AW:0]);
  wire push    = wr_req & ~full;
  assign ovf_set = wr_req & full;
  wire [7:0] head = silo_mem[rp_ff];
  wire empty   = (count == {(AW+1){1'b0}});
  // Head LF on bottom row with top line pending holds the LF and everything behind it
  wire head_block = (head == `PFS_CH_LF) & stall_lf & ~pt_ff;
  wire pt_hold = pt_ff & prn_valid_o & ~prn_ready_i;
  wire pop = ~empty & ~stall & ~head_block & ~pt_hold & ~line_busy;

  // Everything from the host goes through the silo so order is kept
  always @(posedge clk_i) begin
    if (push)
      silo_mem[wp_ff] <= wr_data[7:0];
  end
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      wp_ff <= {AW{1'b0}};
      rp_ff <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (push)
        wp_ff <= wp_ff + 1'b1;
      if (pop)
        rp_ff <= rp_ff + 1'b1;
      count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end

  // ==========================================================
  // Command decode, processing and pass-through
  reg [1:0] dec_ff;
  reg       id_req_ff;
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      dec_ff       <= `PFS_D_IDLE;
      pt_ff        <= 1'b0;
      busy_ff      <= 1'b0;
      id_req_ff    <= 1'b0;
      proc_valid_o <= 1'b0;
      proc_data_o  <= 8'h0;
      lf_queue_o   <= 1'b0;
    end else begin
      proc_valid_o <= 1'b0;
      lf_queue_o   <= 1'b0;
      if (print_req_i)
        busy_ff <= 1'b1;
      // Stall lasts until the last byte of the line has been taken by the printer
      else if (~print_busy_i & ~line_busy & ~prn_valid_o)
        busy_ff <= 1'b0;
      if (id_sent)
        id_req_ff <= 1'b0;
      if (pop) begin
        case (dec_ff)
          `PFS_D_IDLE: begin
            if (pt_ff & (head == `PFS_CH_ESC))
              dec_ff <= `PFS_D_PT_ESC;
            else if (~pt_ff & (head == `PFS_CH_ESC))
              dec_ff <= `PFS_D_ESC;
            else if (~pt_ff) begin
              proc_valid_o <= 1'b1;
              proc_data_o  <= head;
              lf_queue_o   <= line_follow_i & (head == `PFS_CH_LF);
            end
          end
          `PFS_D_ESC: begin
            dec_ff <= `PFS_D_IDLE;
            if (head == `PFS_CH_IDENT)
              id_req_ff <= 1'b1;
            else if (head == `PFS_CH_PT_ENTER)
              pt_ff <= 1'b1;
            else if (head == `PFS_CH_PLINE)
              busy_ff <= 1'b1;
            else begin
              proc_valid_o <= 1'b1;
              proc_data_o  <= head;
            end
          end
          `PFS_D_PT_ESC: begin
            dec_ff <= (head == `PFS_CH_ESC) ? `PFS_D_PT_ESC : `PFS_D_IDLE;
            if (head == `PFS_CH_PT_EXIT)
              pt_ff <= 1'b0;
          end
          default: dec_ff <= `PFS_D_IDLE;
        endcase
      end
    end
  end

  // ==========================================================
  // Printer stream: raw pass-through or one screen line
  reg [1:0] tail_ff;     // 0 columns, 1 CR, 2 LF
  wire prn_take = prn_valid_o & prn_ready_i;
  // Print-cursor-line from the host starts the line here; the screen engine only serves columns
  wire pline_cmd = pop & ~pt_ff & (dec_ff == `PFS_D_ESC) & (head == `PFS_CH_PLINE);
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      prn_valid_o <= 1'b0;
      prn_data_o  <= 8'h0;
      line_busy   <= 1'b0;
      tail_ff     <= 2'h0;
      col_addr_o  <= 7'h0;
      line_done_o <= 1'b0;
    end else begin
      line_done_o <= 1'b0;
      if (prn_take)
        prn_valid_o <= 1'b0;
      if (pop & pt_ff & (prn_take | ~prn_valid_o)) begin
        // ESC forwarded at once; exit byte becomes CAN
        prn_valid_o <= 1'b1;
        prn_data_o  <= ((dec_ff == `PFS_D_PT_ESC) & (head == `PFS_CH_PT_EXIT)) ? `PFS_CH_CAN : head;
      end else if (~line_busy & (line_start_i | pline_cmd) & ~pt_ff) begin
        line_busy  <= 1'b1;
        tail_ff    <= 2'h0;
        col_addr_o <= 7'h0;
      end else if (line_busy & (prn_take | ~prn_valid_o)) begin
        // Columns left to right, then CR and LF
        prn_valid_o <= 1'b1;
        if (tail_ff == 2'h0) begin
          prn_data_o <= col_data_i;
          if (col_addr_o == `PFS_COL_LAST)
            tail_ff <= 2'h1;
          else
            col_addr_o <= col_addr_o + 7'h1;
        end else if (tail_ff == 2'h1) begin
          prn_data_o <= `PFS_CH_CR;
          tail_ff    <= 2'h2;
        end else begin
          prn_data_o  <= `PFS_CH_LF;
          line_busy   <= 1'b0;
          line_done_o <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Host transmit: flow control first, then identify, then keyboard
  reg  [1:0] id_idx_ff;
  // Mark is worked out at full width, then cut to the counter width on purpose
  wire [31:0] hi_mark_w = DEPTH - HEADROOM;
  wire [AW:0] hi_mark = hi_mark_w[AW:0];
  // Pass-through XOFF only when the silo backs up, so a slow host never sees one
  wire want_off = stall | head_block | (count >= hi_mark);
  wire want_on  = xoff_ff & ~want_off & empty;
  wire send_fc  = (want_off & ~xoff_ff) | want_on;
  wire send_id  = ~send_fc & id_req_ff;
  assign id_sent = send_id & tx_ready_i & (id_idx_ff == 2'h2);
  // A host char arriving in a local-copy stall holds the key back a cycle, so the silo takes one write
  assign send_kb = ~send_fc & ~id_req_ff & kbd_valid_i & ~(local_ff & stall & rx_valid_i);
  assign tx_valid_o = send_fc | send_id | send_kb;
  // Host is trusted to obey XOFF; overflow is only flagged
  always @* begin
    if (send_fc)
      tx_data_o = xoff_ff ? `PFS_CH_XON : `PFS_CH_XOFF;
    else if (send_id)
      case (id_idx_ff)
        2'h0:    tx_data_o = `PFS_CH_ESC;
        2'h1:    tx_data_o = `PFS_CH_SLASH;
        default: tx_data_o = prn_able ? `PFS_ID_PRN : `PFS_ID_NOPRN;
      endcase
    else
      tx_data_o = kbd_data_i;
  end
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      xoff_ff   <= 1'b0;
      id_idx_ff <= 2'h0;
    end else begin
      if (send_fc & tx_ready_i)
        xoff_ff <= ~xoff_ff;
      if (send_id & tx_ready_i)
        id_idx_ff <= id_sent ? 2'h0 : id_idx_ff + 2'h1;
    end
  end

endmodule // pfs_print_flow
`default_nettype wire

// ===== testbench/pfs_print_flow_bench.sv
/*
 * Bench for pfs_print_flow: registers, identify, line print, stalls, pass-through.
 * Assumes design sources and the printer model are compiled before it.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pfs_consts.vh"
module pfs_print_flow_bench;
  // ====
  // Signals
  logic clk_i, nrst_i, rx_valid_i, kbd_valid_i, tx_valid_o, tx_ready_i, proc_valid_o, slow;
  logic line_follow_i, cursor_up_pending_i, cursor_bottom_i, top_pending_i, print_req_i;
  logic print_busy_i, line_start_i, line_done_o, lf_queue_o, prn_valid_o, prn_ready_i;
  logic prn_dtr_i, prn_online_i, prn_paper_fault_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]  rx_data_i, kbd_data_i, tx_data_o, proc_data_o, col_data_i, prn_data_o;
  logic [6:0]  col_addr_o;
  logic [2:0]  selector_i;
  logic [3:0]  wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [7:0]  txq[$], procq[$];
  int          failures, num_checks, cyc_n, lfs;
  bit          host_off;
  // Small silo so pacing shows within a short run
  pfs_print_flow #(.AW(3), .DEPTH(8), .HEADROOM(2)) i_pfs_print_flow (
    .clk_i(clk_i), .nrst_i(nrst_i), .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i),
    .kbd_valid_i(kbd_valid_i), .kbd_data_i(kbd_data_i), .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o),
    .tx_ready_i(tx_ready_i), .proc_valid_o(proc_valid_o), .proc_data_o(proc_data_o),
    .line_follow_i(line_follow_i), .cursor_up_pending_i(cursor_up_pending_i), .cursor_bottom_i(cursor_bottom_i),
    .top_pending_i(top_pending_i), .print_req_i(print_req_i), .print_busy_i(print_busy_i),
    .line_start_i(line_start_i), .col_addr_o(col_addr_o), .col_data_i(col_data_i), .line_done_o(line_done_o),
    .lf_queue_o(lf_queue_o), .prn_valid_o(prn_valid_o), .prn_data_o(prn_data_o), .prn_ready_i(prn_ready_i),
    .selector_i(selector_i), .prn_dtr_i(prn_dtr_i), .prn_online_i(prn_online_i),
    .prn_paper_fault_i(prn_paper_fault_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
  pfs_printer_model i_pfs_printer_model (.clk_i(clk_i), .valid_i(prn_valid_o), .data_i(prn_data_o),
    .ready_o(prn_ready_i), .slow_i(slow));
  // Screen memory: column n holds 0x20 plus n
  assign col_data_i = 8'h20 + {1'h0, col_addr_o};
  initial begin
    clk_i = 1'h0;
    forever #2 clk_i = ~clk_i;
  end
  // Host capture, flow state and hang guard
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000) begin
      failures++;
      give_verdict();
    end
    if (tx_valid_o && tx_ready_i) begin
      txq.push_back(tx_data_o);
      if (tx_data_o == `PFS_CH_XOFF) host_off <= 1'h1;
      if (tx_data_o == `PFS_CH_XON) host_off <= 1'h0;
    end
    if (proc_valid_o) procq.push_back(proc_data_o);
    if (lf_queue_o) lfs++;
  end
  // ====
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'h1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask
  // Host char; a paced host waits out XOFF
  task automatic send(input logic [7:0] b, input bit fc = 1'b0);
    while (fc && host_off) @(posedge clk_i);
    @(posedge clk_i);
    rx_valid_i <= 1'h1;
    rx_data_i  <= b;
    @(posedge clk_i);
    rx_valid_i <= 1'h0;
  endtask
  // ====
  // Scenarios
  task automatic t_ident(input logic [2:0] s, input logic d, input logic on, input logic pf);
    logic ok;
    ok = (s == `PFS_SEL_PARALLEL) ? (on && !pf) : d;
    @(posedge clk_i);
    selector_i <= s;
    prn_dtr_i <= d;
    prn_online_i <= on;
    prn_paper_fault_i <= pf;
    txq.delete();
    send(`PFS_CH_ESC);
    send(`PFS_CH_IDENT);
    idle(20);
    chk(txq.size(), 3);
    chk({txq[0], txq[1]}, {`PFS_CH_ESC, `PFS_CH_SLASH});
    chk(txq[2], ok ? `PFS_ID_PRN : `PFS_ID_NOPRN);
    wb(1'h0, `PFS_REG_STAT, 32'h0);
    chk(rd[4], ok);
  endtask
  task automatic t_line();
    int n;
    txq.delete();
    procq.delete();
    @(posedge clk_i);
    slow <= 1'h1;
    print_req_i <= 1'h1;
    print_busy_i <= 1'h1;
    line_start_i <= 1'h1;
    @(posedge clk_i);
    print_req_i <= 1'h0;
    line_start_i <= 1'h0;
    send("a");
    send("b");
    send("c");
    for (n = 0; n < 2000 && line_done_o !== 1'h1; n++) @(posedge clk_i);
    idle(40);
    chk(procq.size(), 0);
    chk(txq[0], `PFS_CH_XOFF);
    for (n = 0; n < 80; n++) chk(i_pfs_printer_model.got[n], 8'h20 + n);
    chk({i_pfs_printer_model.got[80], i_pfs_printer_model.got[81]}, {`PFS_CH_CR, `PFS_CH_LF});
    print_busy_i <= 1'h0;
    idle(30);
    chk({procq[0], procq[1], procq[2]}, "abc");
    chk(txq[$], `PFS_CH_XON);
  endtask
  task automatic t_follow(input logic up, input logic bot, input logic top, input logic hold);
    int n;
    @(posedge clk_i);
    line_follow_i <= 1'h1;
    cursor_up_pending_i <= up;
    cursor_bottom_i <= bot;
    top_pending_i <= top;
    procq.delete();
    lfs = 0;
    send(`PFS_CH_LF);
    kbd_valid_i <= 1'h1;
    kbd_data_i <= "k";
    for (n = 0; n < 50 && !(tx_valid_o === 1'h1 && tx_data_o === "k"); n++) @(posedge clk_i);
    kbd_valid_i <= 1'h0;
    chk(n < 50, 1'h1);
    idle(20);
    chk(procq.size(), !hold);
    cursor_up_pending_i <= 1'h0;
    top_pending_i <= 1'h0;
    idle(20);
    chk(lfs, 1);
    line_follow_i <= 1'h0;
  endtask
  task automatic t_pass(input logic slw, input int gap);
    int k;
    @(posedge clk_i);
    slow <= slw;
    txq.delete();
    i_pfs_printer_model.got.delete();
    send(`PFS_CH_ESC);
    send(`PFS_CH_PT_ENTER);
    for (k = 0; k < 12; k++) begin
      send(8'(8'h41 + k), 1'b1);
      idle(gap);
    end
    send(`PFS_CH_ESC, 1'b1);
    send(`PFS_CH_PT_EXIT, 1'b1);
    idle(200);
    for (k = 0; k < 12; k++) chk(i_pfs_printer_model.got[k], 8'h41 + k);
    chk({i_pfs_printer_model.got[12], i_pfs_printer_model.got[13]}, {`PFS_CH_ESC, `PFS_CH_CAN});
    chk(txq.size() != 0, slw);
  endtask
  // Print-cursor-line from the host holds later characters until the whole line is out
  task automatic t_pline();
    int n;
    procq.delete();
    i_pfs_printer_model.got.delete();
    send(`PFS_CH_ESC);
    send(`PFS_CH_PLINE);
    send("z");
    for (n = 0; n < 500 && line_done_o !== 1'h1; n++) @(posedge clk_i);
    chk(procq.size(), 0);
    idle(20);
    chk(i_pfs_printer_model.got.size(), 82);
    chk(procq.size(), 1);
    chk(procq[0], "z");
  endtask
  // Local copy: a key typed during a stall goes to the host and into the silo
  task automatic t_local();
    int n;
    wb(1'h1, `PFS_REG_CTRL, 32'h1);
    procq.delete();
    @(posedge clk_i);
    print_req_i <= 1'h1;
    print_busy_i <= 1'h1;
    @(posedge clk_i);
    print_req_i <= 1'h0;
    kbd_valid_i <= 1'h1;
    kbd_data_i <= "q";
    for (n = 0; n < 50 && !(tx_valid_o === 1'h1 && tx_data_o === "q"); n++) @(posedge clk_i);
    kbd_valid_i <= 1'h0;
    chk(n < 50, 1'h1);
    wb(1'h0, `PFS_REG_SLIPTR, 32'h0);
    chk(rd, 1);
    chk(procq.size(), 0);
    print_busy_i <= 1'h0;
    idle(20);
    chk(procq.size(), 1);
    chk(procq[0], "q");
    wb(1'h1, `PFS_REG_CTRL, 32'h0);
  endtask
  // ====
  // Verdict and main sequence
  task automatic give_verdict();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    {nrst_i, rx_valid_i, kbd_valid_i, line_follow_i, cursor_up_pending_i, cursor_bottom_i} = 6'h0;
    {top_pending_i, print_req_i, print_busy_i, line_start_i, prn_paper_fault_i, slow} = 6'h0;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, rx_data_i, kbd_data_i} = 55'h0;
    {tx_ready_i, prn_dtr_i, prn_online_i, selector_i, wb_sel_i} = {3'h7, 3'h1, 4'hf};
    idle(8);
    nrst_i <= 1'h1;
    idle(3);
    chk({tx_valid_o, proc_valid_o, prn_valid_o, wb_ack_o, line_done_o, lf_queue_o}, 0);
    wb(1'h0, `PFS_REG_SLIPTR, 32'h0);
    chk(rd, 0);
    wb(1'h0, 4'hc, 32'h0);
    chk(rd, 0);
    wb(1'h1, `PFS_REG_CTRL, 32'h1);
    wb(1'h0, `PFS_REG_CTRL, 32'h0);
    chk(rd, 1);
    wb(1'h1, `PFS_REG_CTRL, 32'h0);
    t_ident(3'h1, 1'h0, 1'h1, 1'h0);
    t_ident(3'h1, 1'h1, 1'h0, 1'h0);
    t_ident(3'h1, 1'h1, 1'h1, 1'h1);
    t_ident(3'h3, 1'h0, 1'h1, 1'h0);
    t_ident(3'h7, 1'h1, 1'h0, 1'h1);
    t_line();
    t_follow(1'h1, 1'h0, 1'h0, 1'h1);
    t_follow(1'h0, 1'h1, 1'h1, 1'h1);
    t_follow(1'h0, 1'h0, 1'h1, 1'h0);
    t_pass(1'h1, 0);
    t_pass(1'h0, 20);
    t_pline();
    t_local();
    give_verdict();
  end
endmodule // pfs_print_flow_bench
`default_nettype wire

// ===== testbench/pfs_print_flow_monitor.sv
/*
 * Port assertions for the print flow block.
 * Assumes binding into every pfs_print_flow instance, single clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
module pfs_print_flow_monitor (
  // Clock, reset, bus
  input wire logic       clk_i, nrst_i, wb_cyc_i, wb_stb_i, wb_ack_o,
  // Screen engine side
  input wire logic       line_follow_i, cursor_up_pending_i, cursor_bottom_i, top_pending_i,
  input wire logic       proc_valid_o, line_done_o, lf_queue_o,
  input wire logic [7:0] proc_data_o,
  input wire logic [6:0] col_addr_o,
  // Printer and host streams
  input wire logic       prn_valid_o, prn_ready_i, kbd_valid_i, tx_valid_o, tx_ready_i,
  input wire logic [7:0] prn_data_o, kbd_data_i, tx_data_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // ====
  // Bus answer timing
  property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("bus ack late");
  property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_one: assert property (p_ack_one) else $error("bus ack held");
  // ====
  // Printer stream and line fetch
  property p_prn_hold; prn_valid_o && !prn_ready_i |=> prn_valid_o && $stable(prn_data_o); endproperty
  a_prn_hold: assert property (p_prn_hold) else $error("printer byte dropped");
  property p_col_range; col_addr_o <= 7'h4f; endproperty
  a_col_range: assert property (p_col_range) else $error("column out of line");
  property p_done_one; line_done_o |=> !line_done_o; endproperty
  a_done_one: assert property (p_done_one) else $error("line done held");
  // ====
  // Stalls; three cycles allow for the registered hand-off
  property p_stall_up; (line_follow_i && cursor_up_pending_i) [*3] |-> !proc_valid_o; endproperty
  a_stall_up: assert property (p_stall_up) else $error("char processed on pending line");
  property p_stall_top;
    (line_follow_i && top_pending_i && cursor_bottom_i) [*3] |-> !(proc_valid_o && proc_data_o == 8'h0a);
  endproperty
  a_stall_top: assert property (p_stall_top) else $error("scroll lost top line");
  property p_kbd_tx; kbd_valid_i && tx_ready_i |-> ##[0:40] (tx_valid_o && tx_data_o == kbd_data_i); endproperty
  a_kbd_tx: assert property (p_kbd_tx) else $error("key not sent");
  property p_lf_q; proc_valid_o && proc_data_o == 8'h0a && line_follow_i |-> ##[0:2] lf_queue_o; endproperty
  a_lf_q: assert property (p_lf_q) else $error("line not queued");
endmodule // pfs_print_flow_monitor
bind pfs_print_flow pfs_print_flow_monitor i_pfs_print_flow_monitor (
  .clk_i(clk_i), .nrst_i(nrst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .line_follow_i(line_follow_i), .cursor_up_pending_i(cursor_up_pending_i), .cursor_bottom_i(cursor_bottom_i),
  .top_pending_i(top_pending_i), .proc_valid_o(proc_valid_o), .line_done_o(line_done_o), .lf_queue_o(lf_queue_o),
  .proc_data_o(proc_data_o), .col_addr_o(col_addr_o), .prn_valid_o(prn_valid_o), .prn_ready_i(prn_ready_i),
  .kbd_valid_i(kbd_valid_i), .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i), .prn_data_o(prn_data_o),
  .kbd_data_i(kbd_data_i), .tx_data_o(tx_data_o));
`default_nettype wire

// ===== testbench/pfs_printer_model.sv
/*
 * Printer model: takes bytes on a valid/ready stream, fast or one per eight cycles.
 * Assumes the bench reads and clears the got queue.
 */
`timescale 1ns/1ps
`default_nettype none
module pfs_printer_model (
  // Clock
  input  wire logic       clk_i,
  // Byte stream from the block
  input  wire logic       valid_i,
  input  wire logic [7:0] data_i,
  output var  logic       ready_o,
  // Pace select
  input  wire logic       slow_i
);
  logic [2:0] pace_ff = 3'h0;
  logic [7:0] got[$];
  // Slow pace stands in for a slow printer line
  always @(posedge clk_i) pace_ff <= pace_ff + 3'h1;
  assign ready_o = !slow_i || pace_ff == 3'h7;
  // Log every accepted byte
  always @(posedge clk_i) if (valid_i && ready_o) got.push_back(data_i);
endmodule // pfs_printer_model
`default_nettype wire
